/* File: design/interrupt_latch_and_vector_map.sv */
// Interrupt latch, arbitration and vector selection with AXI4-Lite register access
`timescale 1ns/1ns
module interrupt_latch_and_vector_map
    import int_latch_pkg::*;
(
    // Clock and reset
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]   i_s_axi_awaddr,
    input  wire logic                i_s_axi_awvalid,
    output      logic                o_s_axi_awready,
    input  wire logic [31:0]         i_s_axi_wdata,
    input  wire logic [3:0]          i_s_axi_wstrb,
    input  wire logic                i_s_axi_wvalid,
    output      logic                o_s_axi_wready,
    output      logic [1:0]          o_s_axi_bresp,
    output      logic                o_s_axi_bvalid,
    input  wire logic                i_s_axi_bready,
    input  wire logic [ADDR_W-1:0]   i_s_axi_araddr,
    input  wire logic                i_s_axi_arvalid,
    output      logic                o_s_axi_arready,
    output      logic [31:0]         o_s_axi_rdata,
    output      logic [1:0]          o_s_axi_rresp,
    output      logic                o_s_axi_rvalid,
    input  wire logic                i_s_axi_rready,
    // External request pins, active low
    input  wire logic                i_maskable_ext_request_n,
    input  wire logic                i_nonmaskable_ext_request_n,
    // Peripheral sources
    input  wire periph_flags_t       i_periph_flags,
    input  wire logic                i_clock_monitor_fail,
    // CPU core
    input  wire logic                i_cc_int_mask,
    input  wire logic                i_cc_xint_mask,
    input  wire logic                i_vector_fetch,
    output      vector_out_t         o_vector,
    output      logic                o_maskable_request,
    output      logic                o_nonmaskable_request,
    output      logic                o_clock_monitor_reset,
    // Interrupt line
    output      logic                o_int
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [IDX_W-1:0] code_to_index(input logic [7:0] code);
        logic [IDX_W-1:0] idx;
        idx = IDX_NONE;
        for (int k = 0; k < NUM_SRC; k++)
        begin
            if (SRC_CODE[k] == code)
                idx = IDX_W'(k);
        end
        return idx;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]          prio_reg;
    logic [1:0]          intctl_reg;
    logic [7:0]          local_en_reg;
    logic [EV_W-1:0]     status_reg;
    logic [EV_W-1:0]     enable_reg;
    logic                ext_prev_reg;
    logic                ext_edge_reg;
    vector_out_t         vector_reg;

    logic                aw_have_reg;
    logic                w_have_reg;
    logic [ADDR_W-1:0]   aw_addr_reg;
    logic [31:0]         w_data_reg;
    logic [3:0]          w_strb_reg;
    logic                bvalid_reg;
    logic [1:0]          bresp_reg;
    logic                rvalid_reg;
    logic [31:0]         rdata_reg;
    logic [1:0]          rresp_reg;

    // ------------------------------------------------------------
    // Request formation
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0]  src_req;
    logic                ext_falling;
    logic                ext_level_req;
    logic                cm_req;
    logic                nonmask_req;
    logic                any_maskable;
    logic [IDX_W-1:0]    win_idx;
    logic [IDX_W-1:0]    elev_idx;
    logic [EV_W-1:0]     ev_set;
    logic                edge_serviced;

    assign ext_falling   = ext_prev_reg & ~i_maskable_ext_request_n;
    assign ext_level_req = intctl_reg[POS_CONNECT_EN] & ~i_maskable_ext_request_n;

    always_comb
    begin
        src_req[0] = intctl_reg[POS_EDGE_SEL] ? ext_edge_reg : ext_level_req;
        src_req[1] = i_periph_flags.accumulator_edge & local_en_reg[POS_PA_EDGE];
        src_req[2] = i_periph_flags.serial_done & local_en_reg[POS_SERIAL];
        src_req[3] = i_periph_flags.down_counter_underflow & local_en_reg[POS_DOWNCNT];
        src_req[4] = i_periph_flags.accumulator_b_overflow & local_en_reg[POS_PB_OVF];
        src_req[5] = (i_periph_flags.clock_lock & local_en_reg[POS_LOCK])
                   | (i_periph_flags.limp_home & local_en_reg[POS_LIMP]);
    end

    // Peripheral flags are live levels; the block stores none of them
    assign cm_req        = i_clock_monitor_fail
                         & (local_en_reg[POS_CLOCK_MON_EN] | local_en_reg[POS_FORCED_MON_EN]);
    assign nonmask_req   = ~i_nonmaskable_ext_request_n & ~i_cc_xint_mask;
    assign any_maskable  = ~i_cc_int_mask & (|src_req);

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    always_comb
    begin
        elev_idx = code_to_index(prio_reg);
        if (elev_idx == IDX_NONE)
            elev_idx = IDX_EXT;
        win_idx = IDX_NONE;
        for (int k = NUM_SRC - 1; k >= 0; k--)
        begin
            if (src_req[k])
                win_idx = IDX_W'(k);
        end
        if (src_req[elev_idx])
            win_idx = elev_idx;
    end

    assign o_maskable_request    = any_maskable;
    assign o_nonmaskable_request = nonmask_req;
    assign o_clock_monitor_reset = cm_req;
    assign edge_serviced = i_vector_fetch & ~cm_req & ~nonmask_req & any_maskable
                         & (win_idx == IDX_EXT) & intctl_reg[POS_EDGE_SEL];

    // ------------------------------------------------------------
    // Edge latch of the maskable pin
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            ext_prev_reg <= 1'b1;
        else
            ext_prev_reg <= i_maskable_ext_request_n;
    end

    // A new edge in the service cycle survives the automatic clear
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            ext_edge_reg <= 1'b0;
        else if (ext_falling & intctl_reg[POS_EDGE_SEL] & intctl_reg[POS_CONNECT_EN])
            ext_edge_reg <= 1'b1;
        else if (edge_serviced | ~intctl_reg[POS_EDGE_SEL])
            ext_edge_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // Vector output
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            vector_reg.valid <= 1'b0;
            vector_reg.addr  <= RST_VECTOR;
        end
        else
        begin
            vector_reg.valid <= i_vector_fetch;
            if (i_vector_fetch)
            begin
                if (cm_req)
                    vector_reg.addr <= {VEC_HIGH_BYTE, CODE_CLOCK_MON};
                else if (nonmask_req)
                    vector_reg.addr <= {VEC_HIGH_BYTE, CODE_NONMASK_EXT};
                else if (any_maskable)
                    vector_reg.addr <= {VEC_HIGH_BYTE, SRC_CODE[win_idx]};
                else
                    vector_reg.addr <= {VEC_HIGH_BYTE, CODE_TRAP};
            end
        end
    end

    assign o_vector = vector_reg;

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    logic wr_fire;
    logic wr_mapped;
    assign o_s_axi_awready = ~aw_have_reg & ~bvalid_reg;
    assign o_s_axi_wready  = ~w_have_reg & ~bvalid_reg;
    assign wr_fire         = aw_have_reg & w_have_reg & ~bvalid_reg;
    assign wr_mapped       = (aw_addr_reg == OFS_PRIO) | (aw_addr_reg == OFS_INTCTL)
                           | (aw_addr_reg == OFS_LOCAL_EN) | (aw_addr_reg == OFS_CLEAR)
                           | (aw_addr_reg == OFS_ENABLE) | (aw_addr_reg == OFS_STATUS)
                           | (aw_addr_reg == OFS_LAST_VEC) | (aw_addr_reg == OFS_PENDING);

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
        end
        else
        begin
            if (i_s_axi_awvalid & o_s_axi_awready)
            begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= {i_s_axi_awaddr[ADDR_W-1:2], 2'b00};
            end
            else if (wr_fire)
                aw_have_reg <= 1'b0;
            if (i_s_axi_wvalid & o_s_axi_wready)
            begin
                w_have_reg <= 1'b1;
                w_data_reg <= i_s_axi_wdata;
                w_strb_reg <= i_s_axi_wstrb;
            end
            else if (wr_fire)
                w_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_DECERR;
        end
        else if (i_s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    assign o_s_axi_bvalid = bvalid_reg;
    assign o_s_axi_bresp  = bresp_reg;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic wr_low;
    logic prio_refused;
    assign wr_low       = wr_fire & w_strb_reg[0];
    assign prio_refused = wr_low & (aw_addr_reg == OFS_PRIO) & ~i_cc_int_mask;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            prio_reg <= RST_PRIO;
        else if (wr_low & (aw_addr_reg == OFS_PRIO) & i_cc_int_mask)
            prio_reg <= w_data_reg[7:0];
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            intctl_reg   <= RST_INTCTL;
            local_en_reg <= RST_LOCAL_EN;
            enable_reg   <= '0;
        end
        else if (wr_low)
        begin
            if (aw_addr_reg == OFS_INTCTL)
                intctl_reg <= w_data_reg[1:0];
            if (aw_addr_reg == OFS_LOCAL_EN)
                local_en_reg <= w_data_reg[7:0];
            if (aw_addr_reg == OFS_ENABLE)
                enable_reg <= w_data_reg[EV_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Event status and interrupt line
    // ------------------------------------------------------------
    always_comb
    begin
        ev_set              = '0;
        ev_set[EV_TRAP]     = i_vector_fetch & ~cm_req & ~nonmask_req & ~any_maskable;
        ev_set[EV_REFUSED]  = prio_refused;
        ev_set[EV_SERVICED] = i_vector_fetch;
    end

    // Set wins over a clear in the same cycle so no event is dropped
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            status_reg <= '0;
        else if (wr_low & (aw_addr_reg == OFS_CLEAR))
            status_reg <= (status_reg & ~w_data_reg[EV_W-1:0]) | ev_set;
        else
            status_reg <= status_reg | ev_set;
    end

    assign o_int = |(status_reg & enable_reg);

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] rd_addr;
    assign o_s_axi_arready = ~rvalid_reg;
    assign rd_addr         = {i_s_axi_araddr[ADDR_W-1:2], 2'b00};

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end
        else if (i_s_axi_arvalid & o_s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            unique case (rd_addr)
                OFS_PRIO:     rdata_reg <= {24'h000000, prio_reg};
                OFS_INTCTL:   rdata_reg <= {30'h00000000, intctl_reg};
                OFS_LOCAL_EN: rdata_reg <= {24'h000000, local_en_reg};
                OFS_STATUS:   rdata_reg <= {29'h00000000, status_reg};
                OFS_CLEAR:    rdata_reg <= 32'h00000000;
                OFS_ENABLE:   rdata_reg <= {29'h00000000, enable_reg};
                OFS_LAST_VEC: rdata_reg <= {16'h0000, vector_reg.addr};
                OFS_PENDING:  rdata_reg <= {25'h0000000, ext_edge_reg, src_req};
                default:
                begin
                    rdata_reg <= 32'h00000000;
                    rresp_reg <= RESP_DECERR;
                end
            endcase
        end
        else if (i_s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    assign o_s_axi_rvalid = rvalid_reg;
    assign o_s_axi_rdata  = rdata_reg;
    assign o_s_axi_rresp  = rresp_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    AST_NONMASK_LEVEL: assert property (
        o_nonmaskable_request == (~i_nonmaskable_ext_request_n & ~i_cc_xint_mask))
        else $error("non-maskable request not a pure level");
    AST_LEVEL_MODE: assert property (
        ~intctl_reg[POS_EDGE_SEL] |-> src_req[0] == ext_level_req)
        else $error("level mode request wrong");
    AST_TRAP_VECTOR: assert property (
        i_vector_fetch & ~cm_req & ~nonmask_req & ~any_maskable
        |=> vector_reg.valid && vector_reg.addr == 16'hfff8)
        else $error("trap vector not taken");
    AST_EDGE_CAPTURE: assert property (
        ext_falling & intctl_reg[POS_EDGE_SEL] & intctl_reg[POS_CONNECT_EN] |=> ext_edge_reg)
        else $error("falling edge not latched");
    AST_EDGE_HOLD: assert property (
        ext_edge_reg & intctl_reg[POS_EDGE_SEL] & ~edge_serviced |=> ext_edge_reg)
        else $error("edge latch lost before service");
    AST_EDGE_AUTOCLR: assert property (
        edge_serviced & ~ext_falling |=> ~ext_edge_reg)
        else $error("edge latch not cleared on service");
    AST_CLOCK_MON: assert property (
        i_vector_fetch & cm_req |=> vector_reg.addr == 16'hfffc)
        else $error("clock monitor vector wrong");
    AST_SHARED_CLOCK_GEN: assert property (
        i_periph_flags.limp_home & local_en_reg[POS_LIMP] |-> src_req[5])
        else $error("limp-home request not raised");
    AST_ELEVATED: assert property (
        i_vector_fetch & ~cm_req & ~nonmask_req & ~i_cc_int_mask & (prio_reg == 8'hda) & src_req[1]
        |=> vector_reg.addr == 16'hffda)
        else $error("elevated source not chosen");
    AST_ORDER: assert property (
        i_vector_fetch & ~cm_req & ~nonmask_req & ~i_cc_int_mask & (prio_reg == 8'hf2)
        & src_req[2] & src_req[3] & ~src_req[0] & ~src_req[1]
        |=> vector_reg.addr == 16'hffd8)
        else $error("default order violated");
    AST_PRIO_GUARD: assert property (
        wr_low & (aw_addr_reg == OFS_PRIO) & ~i_cc_int_mask |=> $stable(prio_reg))
        else $error("priority register changed while unmasked");
    AST_BAD_CODE: assert property (
        (code_to_index(prio_reg) == IDX_NONE) & src_req[0] |-> win_idx == IDX_EXT)
        else $error("external pin not top for bad code");

    COV_EDGE_SERVICE: cover property (ext_falling ##[1:20] edge_serviced);
    COV_TRAP:         cover property (ev_set[EV_TRAP]);
    COV_REFUSED:      cover property (prio_refused);
    COV_INT_LINE:     cover property ($rose(o_int));

endmodule // interrupt_latch_and_vector_map

/* File: design/int_latch_pkg.sv */
// Package: constants, register map and carrier types of the interrupt latch and vector map
package int_latch_pkg;

    // ------------------------------------------------------------
    // Sources and vectors
    // ------------------------------------------------------------
    localparam int          NUM_SRC          = 6;
    localparam int          IDX_W            = 3;
    localparam logic [2:0]  IDX_EXT          = 3'h0;
    localparam logic [2:0]  IDX_NONE         = 3'h7;
    localparam logic [7:0]  VEC_HIGH_BYTE    = 8'hff;
    localparam logic [7:0]  CODE_CLOCK_MON   = 8'hfc;
    localparam logic [7:0]  CODE_TRAP        = 8'hf8;
    localparam logic [7:0]  CODE_NONMASK_EXT = 8'hf4;
    localparam logic [7:0]  CODE_MASK_TOP    = 8'hf2;
    // Maskable sources, highest vector first
    localparam logic [7:0]  SRC_CODE [NUM_SRC] = '{8'hf2, 8'hda, 8'hd8, 8'hcc, 8'hca, 8'hc2};

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W           = 8;
    localparam logic [7:0]  OFS_PRIO         = 8'h00;
    localparam logic [7:0]  OFS_INTCTL       = 8'h04;
    localparam logic [7:0]  OFS_LOCAL_EN     = 8'h08;
    localparam logic [7:0]  OFS_STATUS       = 8'h0c;
    localparam logic [7:0]  OFS_CLEAR        = 8'h10;
    localparam logic [7:0]  OFS_ENABLE       = 8'h14;
    localparam logic [7:0]  OFS_LAST_VEC     = 8'h18;
    localparam logic [7:0]  OFS_PENDING      = 8'h1c;

    // Field positions
    localparam int          POS_EDGE_SEL     = 0;
    localparam int          POS_CONNECT_EN   = 1;
    localparam int          POS_CLOCK_MON_EN  = 0;
    localparam int          POS_FORCED_MON_EN = 1;
    localparam int          POS_PA_EDGE      = 2;
    localparam int          POS_SERIAL       = 3;
    localparam int          POS_DOWNCNT      = 4;
    localparam int          POS_PB_OVF       = 5;
    localparam int          POS_LOCK         = 6;
    localparam int          POS_LIMP         = 7;
    localparam int          EV_W             = 3;
    localparam int          EV_TRAP          = 0;
    localparam int          EV_REFUSED       = 1;
    localparam int          EV_SERVICED      = 2;

    // Reset values
    localparam logic [7:0]  RST_PRIO         = 8'hf2;
    localparam logic [1:0]  RST_INTCTL       = 2'h2;
    localparam logic [7:0]  RST_LOCAL_EN     = 8'h00;
    localparam logic [15:0] RST_VECTOR       = 16'hfffe;

    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_DECERR      = 2'h3;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic accumulator_edge;
        logic serial_done;
        logic down_counter_underflow;
        logic accumulator_b_overflow;
        logic clock_lock;
        logic limp_home;
    } periph_flags_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } vector_out_t;

endpackage

/* File: bench/periph_model.sv */
// Peripheral flag model: each source flag stays up until the shared clear drops all flags at once
`timescale 1ns/1ns
module periph_model
    import int_latch_pkg::*;
(
    // Clock, handler controls and flags
    input  wire logic          i_clk_sys,
    input  wire logic [5:0]    i_set,
    input  wire logic          i_clr,
    output      periph_flags_t o_flags
);
    // Set wins over clear so one pulse can reload a whole pattern
    always_ff @(posedge i_clk_sys)
        o_flags <= (i_clr ? '0 : o_flags) | i_set;
endmodule // periph_model

/* File: bench/interrupt_latch_and_vector_map_tb.sv */
// Self-checking bench for the interrupt latch and vector map
`timescale 1ns/1ns
module interrupt_latch_and_vector_map_tb
    import int_latch_pkg::*;
;
    logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, mpin = 1, npin = 1, cmf = 0;
    logic im = 1, xm = 1, vf = 0, clr = 1, awr, wr, bv, arr, rv, mreq, intr, cmr, nmr;
    logic [7:0] awa = 0, ara = 0, p, en;
    logic [31:0] wd = 0, rd;
    logic [1:0] rsp, bresp, wresp;
    logic [5:0] fset = 0, f, g;
    logic [7:0] codes [6] = '{8'hc2, 8'hc2, 8'hca, 8'hcc, 8'hd8, 8'hda};
    periph_flags_t flags;
    vector_out_t vec;
    int fails = 0, num_checks = 0, cyc = 0;
    interrupt_latch_and_vector_map DUT (
        .i_clk_sys(clk), .i_rst(rst), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
        .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
        .o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rsp), .o_s_axi_rvalid(rv),
        .i_s_axi_rready(rr), .i_maskable_ext_request_n(mpin), .i_nonmaskable_ext_request_n(npin),
        .i_periph_flags(flags), .i_clock_monitor_fail(cmf), .i_cc_int_mask(im), .i_cc_xint_mask(xm),
        .i_vector_fetch(vf), .o_vector(vec), .o_maskable_request(mreq), .o_nonmaskable_request(nmr),
        .o_clock_monitor_reset(cmr), .o_int(intr));
    periph_model peer (.i_clk_sys(clk), .i_set(fset), .i_clr(clr), .o_flags(flags));
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin fails++; give_verdict; end
    end
    task automatic chk(input logic [33:0] got, exp);
        num_checks++;
        if (got !== exp) begin fails++; $display("unexpected at %0t: got %h exp %h", $time, got, exp); end
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {awa, wd, awv, wv, br} <= {a, d, 3'b111};
        do begin @(posedge clk); if (awr) awv <= 0; if (wr) wv <= 0; end while (awv || wv);
        do @(posedge clk); while (!bv);
        br <= 0;
        wresp = bresp;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [33:0] e);
        @(posedge clk);
        {ara, arv, rr} <= {a, 2'b11};
        do @(posedge clk); while (!arr);
        arv <= 0;
        do @(posedge clk); while (!rv);
        rr <= 0;
        chk({rsp, rd}, e);
    endtask
    // The valid pulse stands one cycle after the fetch edge, the address until the next fetch
    task automatic fetch(input logic [15:0] e);
        @(posedge clk) vf <= 1;
        @(posedge clk) vf <= 0;
        @(posedge clk) chk({vec.valid, vec.addr}, {1'b1, e});
        @(posedge clk) chk(vec.valid, 0);
    endtask
    // Later overwrites win, so sources are visited lowest vector first
    function automatic logic [15:0] expv(logic [5:0] s, logic [7:0] pr);
        expv = 16'hfff8;
        for (int i = 0; i < 6; i++) if (s[i]) expv = {8'hff, codes[i]};
        for (int i = 0; i < 6; i++) if (s[i] && codes[i] == pr) expv = {8'hff, pr};
    endfunction
    initial
    begin
        void'($urandom(11));
        repeat (12) @(posedge clk);
        {rst, clr, im} <= 3'b000;
        rdc(8'h20, {RESP_DECERR, 32'h0});
        axw(OFS_PRIO, 32'hda);
        chk(wresp, RESP_OKAY);
        rdc(OFS_PRIO, 34'hf2);
        rdc(OFS_STATUS, 34'h2);
        fetch(16'hfff8);
        axw(OFS_ENABLE, 32'h1);
        chk(intr, 1);
        axw(OFS_CLEAR, 32'h1);
        chk(intr, 0);
        $display("register test done");
        for (int n = 0; n < 40; n++)
        begin
            {p, en, f} = 22'($urandom);
            p = n[0] ? codes[n % 6] : p;
            g = {<<{en[7:2]}};
            g = g & f;
            im <= 1;
            axw(OFS_PRIO, {24'h0, p});
            axw(OFS_LOCAL_EN, {24'h0, en});
            // Flags are reloaded on the same edge that drives the mask from n[1], so passes with n[1] set stay masked
            {clr, fset} <= {1'b1, f};
            @(posedge clk) {clr, fset, im} <= {7'h0, n[1]};
            fetch(n[1] ? 16'hfff8 : expv(g, p));
            chk(mreq, !n[1] && |g);
        end
        $display("random source test done");
        {clr, im} <= 2'b11;
        axw(OFS_INTCTL, 32'h3);
        im <= 0;
        @(posedge clk) mpin <= 0;
        @(posedge clk) mpin <= 1;
        fetch(16'hfff2);
        fetch(16'hfff8);
        axw(OFS_INTCTL, 32'h2);
        mpin <= 0;
        fetch(16'hfff2);
        fetch(16'hfff2);
        mpin <= 1;
        fetch(16'hfff8);
        {npin, xm} <= 2'b00;
        fetch(16'hfff4);
        fetch(16'hfff4);
        chk(nmr, 1);
        axw(OFS_LOCAL_EN, 32'h1);
        cmf <= 1;
        fetch(16'hfffc);
        chk(cmr, 1);
        $display("pin and monitor test done");
        give_verdict;
    end
endmodule // interrupt_latch_and_vector_map_tb
